// file: common/tcdt_regs.svh
// Timing constants for the Type-C CC/VBUS debounce timer block
`ifndef TCDT_REGS_SVH
`define TCDT_REGS_SVH
`define TCDT_CLK_KHZ        200000
`define TCDT_SRC_DEB_US     150000
`define TCDT_SNK_DEB_US     75000
`define TCDT_DET_DEB_US     15000
`define TCDT_ACC_DEB_US     100000
`define TCDT_REC_US         50000
`define TCDT_VON_NS         200000
`define TCDT_VOFF_US        15000
`define TCDT_GLITCH_NS      50
`define TCDT_CYC_US(t)      ((t) * (`TCDT_CLK_KHZ / 1000))
`define TCDT_CYC_NS(t)      (((t) * (`TCDT_CLK_KHZ / 1000) + 999) / 1000)
`define TCDT_DWELL_LSB      4
`define TCDT_DWELL_MSB      5
`define TCDT_FORCE_BIT      0
`define TCDT_MODE_RST       6'h04
`define TCDT_SNK_DW0_MS     35
`define TCDT_SNK_DW1_MS     30
`define TCDT_SNK_DW2_MS     25
`define TCDT_SNK_DW3_MS     20
`define TCDT_SRC_DW0_MS     15
`define TCDT_SRC_DW1_MS     20
`define TCDT_SRC_DW2_MS     25
`define TCDT_SRC_DW3_MS     30
`endif

// file: common/tcdt_pkg.sv
// Types for the Type-C debounce timer block
package tcdt_pkg;
  typedef enum logic [1:0] {
    TCDT_ROLE_SRC,
    TCDT_ROLE_SNK,
    TCDT_ROLE_ACC
  } tcdt_role_t;
  typedef enum logic [1:0] {
    TCDT_TOG_SNK,
    TCDT_TOG_SRC,
    TCDT_TOG_REC
  } tcdt_tog_t;
endpackage

// file: design/tcdt_debounce.sv
// Generic restartable debounce filter
`timescale 1ns/1ps
module tcdt_debounce
#(
  parameter int CW = 26
)
(
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          raw_i,
  input  wire logic [CW-1:0] rise_cyc_i,
  input  wire logic [CW-1:0] fall_cyc_i,
  output logic               level_o
);
  logic          level_reg;
  logic          level_next;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic [CW-1:0] target;

  always_comb
  begin
    target     = raw_i ? rise_cyc_i : fall_cyc_i;
    level_next = level_reg;
    cnt_next   = '0;
    // Any change back to the held level restarts the count
    if (raw_i != level_reg)
    begin
      if (cnt_reg + CW'(1) >= target)
        level_next = raw_i;
      else
        cnt_next = cnt_reg + CW'(1);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      level_reg <= 1'b0;
      cnt_reg   <= '0;
    end
    else
    begin
      level_reg <= level_next;
      cnt_reg   <= cnt_next;
    end
  end

  assign level_o = level_reg;

  property p_hold;
    @(posedge clk_i) disable iff (rst_i)
      (raw_i != level_reg) |=> (cnt_reg != '0) || (level_reg == $past(raw_i));
  endproperty
  a_hold : assert property (p_hold)
    else $error("debounce count failed to advance");
endmodule // tcdt_debounce

// file: design/tcdt_timers.sv
// Type-C CC/VBUS debounce, recovery and dual-role toggle timers
`timescale 1ns/1ps
`include "tcdt_regs.svh"
module tcdt_timers
  import tcdt_pkg::*;
#(
  parameter int CW        = 26,
  parameter int SRC_CYC   = `TCDT_CYC_US(`TCDT_SRC_DEB_US),
  parameter int SNK_CYC   = `TCDT_CYC_US(`TCDT_SNK_DEB_US),
  parameter int DET_CYC   = `TCDT_CYC_US(`TCDT_DET_DEB_US),
  parameter int ACC_CYC   = `TCDT_CYC_US(`TCDT_ACC_DEB_US),
  parameter int REC_CYC   = `TCDT_CYC_US(`TCDT_REC_US),
  parameter int VOFF_CYC  = `TCDT_CYC_US(`TCDT_VOFF_US),
  parameter int MS_CYC    = `TCDT_CYC_US(1000)
)
(
  input  wire logic       CLK_SYS_I,
  input  wire logic       RST_I,
  input  wire logic [1:0] CC_ROLE_I,
  input  wire logic       CC_ATTACH_RAW_I,
  input  wire logic       CC_ACC_RAW_I,
  input  wire logic       VBUS_RAW_I,
  input  wire logic [5:0] MODE_I,
  input  wire logic [7:0] CONTROL_I,
  input  wire logic [7:0] MANUAL_WR_I,
  input  wire logic       MANUAL_WE_I,
  input  wire logic       TOGGLE_EN_I,
  input  wire logic       SCL_I,
  input  wire logic       SDA_I,
  output logic            CC_ATTACHED_O,
  output logic            ACC_ATTACHED_O,
  output logic            VBUS_VALID_O,
  output logic            VBUS_VALID_IRQ_O,
  output logic            IN_RECOVERY_O,
  output logic            TOG_SOURCE_O,
  output logic            SCL_FILT_O,
  output logic            SDA_FILT_O
);
  // ****************************************************
  // Timing counts
  // ****************************************************
  localparam int VON_CYC = `TCDT_CYC_NS(`TCDT_VON_NS);
  localparam int GL_CYC  = `TCDT_CYC_NS(`TCDT_GLITCH_NS) + 1;

  logic [CW-1:0] cc_rise;
  logic          vbus_db;
  logic          vbus_db_reg;
  logic [1:0]    dwell_sel;
  logic [5:0]    mode_reg;
  logic          force_cmd;

  // ****************************************************
  // Debounce filters
  // ****************************************************
  always_comb
  begin
    case (CC_ROLE_I)
      TCDT_ROLE_SNK: cc_rise = CW'(SNK_CYC);
      default:       cc_rise = CW'(SRC_CYC);
    endcase
  end

  tcdt_debounce #(.CW(CW)) u_cc
  (
    .clk_i      (CLK_SYS_I),
    .rst_i      (RST_I),
    .raw_i      (CC_ATTACH_RAW_I),
    .rise_cyc_i (cc_rise),
    .fall_cyc_i (CW'(DET_CYC)),
    .level_o    (CC_ATTACHED_O)
  );

  tcdt_debounce #(.CW(CW)) u_acc
  (
    .clk_i      (CLK_SYS_I),
    .rst_i      (RST_I),
    .raw_i      (CC_ACC_RAW_I),
    .rise_cyc_i (CW'(ACC_CYC)),
    .fall_cyc_i (CW'(DET_CYC)),
    .level_o    (ACC_ATTACHED_O)
  );

  tcdt_debounce #(.CW(CW)) u_vbus
  (
    .clk_i      (CLK_SYS_I),
    .rst_i      (RST_I),
    .raw_i      (VBUS_RAW_I),
    .rise_cyc_i (CW'(VON_CYC)),
    .fall_cyc_i (CW'(VOFF_CYC)),
    .level_o    (vbus_db)
  );

  // Short glitch filters; a fixed delay of GL_CYC is the price of rejection
  logic [1:0] gl_in;
  logic [1:0] gl_out;
  assign gl_in = {SDA_I, SCL_I};
  for (genvar g = 0; g < 2; g++)
  begin : g_glitch
    tcdt_debounce #(.CW(4)) u_gl
    (
      .clk_i      (CLK_SYS_I),
      .rst_i      (RST_I),
      .raw_i      (gl_in[g]),
      .rise_cyc_i (4'(GL_CYC)),
      .fall_cyc_i (4'(GL_CYC)),
      .level_o    (gl_out[g])
    );
  end
  assign SCL_FILT_O = gl_out[0];
  assign SDA_FILT_O = gl_out[1];

  // ****************************************************
  // Recovery and dual-role toggle
  // ****************************************************
  tcdt_tog_t     st_reg;
  tcdt_tog_t     st_next;
  logic [CW-1:0] tcnt_reg;
  logic [CW-1:0] tcnt_next;
  logic [CW-1:0] snk_dwell;
  logic [CW-1:0] src_dwell;
  logic          irq_next;

  assign dwell_sel = CONTROL_I[`TCDT_DWELL_MSB:`TCDT_DWELL_LSB];
  // Self-clearing: acts only in the write cycle, never stored
  assign force_cmd = MANUAL_WE_I && MANUAL_WR_I[`TCDT_FORCE_BIT];

  // Midpoint of min..2*min is 1.5*min
  always_comb
  begin
    case (dwell_sel)
      2'h0:    snk_dwell = CW'(MS_CYC * `TCDT_SNK_DW0_MS * 3 / 2);
      2'h1:    snk_dwell = CW'(MS_CYC * `TCDT_SNK_DW1_MS * 3 / 2);
      2'h2:    snk_dwell = CW'(MS_CYC * `TCDT_SNK_DW2_MS * 3 / 2);
      default: snk_dwell = CW'(MS_CYC * `TCDT_SNK_DW3_MS * 3 / 2);
    endcase
    case (dwell_sel)
      2'h0:    src_dwell = CW'(MS_CYC * `TCDT_SRC_DW0_MS * 3 / 2);
      2'h1:    src_dwell = CW'(MS_CYC * `TCDT_SRC_DW1_MS * 3 / 2);
      2'h2:    src_dwell = CW'(MS_CYC * `TCDT_SRC_DW2_MS * 3 / 2);
      default: src_dwell = CW'(MS_CYC * `TCDT_SRC_DW3_MS * 3 / 2);
    endcase
  end

  always_comb
  begin
    st_next   = st_reg;
    tcnt_next = tcnt_reg + CW'(1);
    irq_next  = vbus_db && !vbus_db_reg;
    if (force_cmd || (MODE_I != mode_reg))
    begin
      st_next   = TCDT_TOG_REC;
      tcnt_next = '0;
    end
    else
    begin
      case (st_reg)
        TCDT_TOG_REC:
          if (tcnt_reg + CW'(1) >= CW'(REC_CYC))
          begin
            st_next   = TCDT_TOG_SNK;
            tcnt_next = '0;
          end
        TCDT_TOG_SNK:
          if (!TOGGLE_EN_I || CC_ATTACHED_O)
            tcnt_next = '0;
          else if (tcnt_reg + CW'(1) >= snk_dwell)
          begin
            st_next   = TCDT_TOG_SRC;
            tcnt_next = '0;
          end
        TCDT_TOG_SRC:
          if (!TOGGLE_EN_I)
          begin
            st_next   = TCDT_TOG_SNK;
            tcnt_next = '0;
          end
          else if (CC_ATTACHED_O)
            tcnt_next = '0;
          else if (tcnt_reg + CW'(1) >= src_dwell)
          begin
            st_next   = TCDT_TOG_SNK;
            tcnt_next = '0;
          end
        default:
        begin
          st_next   = TCDT_TOG_SNK;
          tcnt_next = '0;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_I)
  begin
    if (RST_I)
    begin
      st_reg           <= TCDT_TOG_SNK;
      tcnt_reg         <= '0;
      mode_reg         <= `TCDT_MODE_RST;
      vbus_db_reg      <= 1'b0;
      VBUS_VALID_IRQ_O <= 1'b0;
    end
    else
    begin
      st_reg           <= st_next;
      tcnt_reg         <= tcnt_next;
      mode_reg         <= MODE_I;
      vbus_db_reg      <= vbus_db;
      VBUS_VALID_IRQ_O <= irq_next;
    end
  end

  assign VBUS_VALID_O  = vbus_db;
  assign IN_RECOVERY_O = (st_reg == TCDT_TOG_REC);
  assign TOG_SOURCE_O  = (st_reg == TCDT_TOG_SRC);

  // ****************************************************
  // Assertions
  // ****************************************************
  property p_force_rec;
    @(posedge CLK_SYS_I) disable iff (RST_I) force_cmd |=> IN_RECOVERY_O;
  endproperty
  a_force_rec : assert property (p_force_rec)
    else $error("force command did not enter recovery");

  property p_mode_rec;
    @(posedge CLK_SYS_I) disable iff (RST_I)
      (MODE_I != mode_reg) |=> IN_RECOVERY_O && tcnt_reg == '0;
  endproperty
  a_mode_rec : assert property (p_mode_rec)
    else $error("mode change did not restart recovery");

  property p_rec_len;
    @(posedge CLK_SYS_I) disable iff (RST_I)
      (IN_RECOVERY_O && tcnt_reg < CW'(REC_CYC - 1)) |=> IN_RECOVERY_O;
  endproperty
  a_rec_len : assert property (p_rec_len)
    else $error("recovery left early");

  property p_snk_dwell;
    @(posedge CLK_SYS_I) disable iff (RST_I)
      ($rose(TOG_SOURCE_O)) |-> $past(tcnt_reg) + CW'(1) == $past(snk_dwell);
  endproperty
  a_snk_dwell : assert property (p_snk_dwell)
    else $error("sink dwell length wrong");

  property p_src_dwell;
    @(posedge CLK_SYS_I) disable iff (RST_I)
      ($fell(TOG_SOURCE_O) && !IN_RECOVERY_O && $past(TOGGLE_EN_I))
        |-> $past(tcnt_reg) + CW'(1) == $past(src_dwell);
  endproperty
  a_src_dwell : assert property (p_src_dwell)
    else $error("source dwell length wrong");

  property p_irq;
    @(posedge CLK_SYS_I) disable iff (RST_I)
      $rose(vbus_db) |=> VBUS_VALID_IRQ_O ##1 !VBUS_VALID_IRQ_O;
  endproperty
  a_irq : assert property (p_irq)
    else $error("vbus valid interrupt not one pulse");

  property p_vbus_stable;
    @(posedge CLK_SYS_I) disable iff (RST_I)
      $rose(vbus_db) |-> $past(VBUS_RAW_I, 1) && $past(VBUS_RAW_I, 8);
  endproperty
  a_vbus_stable : assert property (p_vbus_stable)
    else $error("vbus reported without stable presence");

  property p_cc_stable;
    @(posedge CLK_SYS_I) disable iff (RST_I)
      $rose(CC_ATTACHED_O) |-> $past(CC_ATTACH_RAW_I, 8);
  endproperty
  a_cc_stable : assert property (p_cc_stable)
    else $error("attach accepted without stable cc");

  property p_detach;
    @(posedge CLK_SYS_I) disable iff (RST_I)
      $fell(CC_ATTACHED_O) |-> !$past(CC_ATTACH_RAW_I, 8);
  endproperty
  a_detach : assert property (p_detach)
    else $error("detach declared without stable removal");

  c_rec    : cover property (@(posedge CLK_SYS_I) $fell(IN_RECOVERY_O));
  c_toggle : cover property (@(posedge CLK_SYS_I) $rose(TOG_SOURCE_O));
  c_attach : cover property (@(posedge CLK_SYS_I) $rose(CC_ATTACHED_O));
  c_vbus   : cover property (@(posedge CLK_SYS_I) VBUS_VALID_IRQ_O);
endmodule // tcdt_timers

// file: dv/tcdt_cc_partner.sv
// Port partner model that presents CC and VBUS levels to the timers
`timescale 1ns/1ps
module tcdt_cc_partner
(
  input  wire logic clk_i,
  input  wire logic attach_i,
  input  wire logic acc_i,
  input  wire logic vbus_i,
  input  wire logic chatter_i,
  output logic      cc_attach_raw_o,
  output logic      cc_acc_raw_o,
  output logic      vbus_raw_o
);
  // Insertion bounce flips every cycle so no level lingers long enough
  logic flip_reg = 1'b0;
  always @(posedge clk_i) flip_reg <= ~flip_reg;
  assign cc_attach_raw_o = chatter_i ? flip_reg : attach_i;
  assign cc_acc_raw_o    = acc_i;
  assign vbus_raw_o      = vbus_i;
endmodule // tcdt_cc_partner

// file: dv/tcdt_timers_tb.sv
// Self-checking bench for the CC/VBUS debounce and toggle timers
`timescale 1ns/1ps
module tcdt_timers_tb;
  import tcdt_pkg::*;
  // Short counts keep the run brief; expectations derive from these, except the glitch filter and VBUS rise counts
  localparam int SRC = 20, SNK = 15, DET = 10, ACC = 18;
  localparam int REC = 12, VOFF = 10, MSC = 20;
  typedef struct { logic [1:0] sel; int a; int b; } tcdt_row_t;
  tcdt_row_t  att_rows [3] = '{'{2'h0, SRC, DET}, '{2'h1, SNK, DET},
                               '{2'h2, SRC, DET}};
  tcdt_row_t  dw_rows [4]  = '{'{2'h0, 35, 15}, '{2'h1, 30, 20},
                               '{2'h2, 25, 25}, '{2'h3, 20, 30}};
  logic       clk = 1'b0, rst = 1'b1, att = 1'b0, acc = 1'b0;
  logic       vb = 1'b0, chat = 1'b0, mwe = 1'b0, tog = 1'b0;
  logic [1:0] role = 2'h1, pins = 2'h3;
  logic [5:0] mode = 6'h04;
  logic [7:0] ctl = 8'h00, mwr = 8'h00;
  wire        att_raw, acc_raw, vb_raw;
  wire  [7:0] obs;
  int         fail_count = 0, cmp_count = 0, n;

  initial
  begin
    forever #2.5 clk = ~clk;
  end

  tcdt_cc_partner u_partner (.clk_i(clk), .attach_i(att), .acc_i(acc),
    .vbus_i(vb), .chatter_i(chat), .cc_attach_raw_o(att_raw),
    .cc_acc_raw_o(acc_raw), .vbus_raw_o(vb_raw));

  tcdt_timers #(.SRC_CYC(SRC), .SNK_CYC(SNK), .DET_CYC(DET),
    .ACC_CYC(ACC), .REC_CYC(REC), .VOFF_CYC(VOFF), .MS_CYC(MSC)) DUT (
    .CLK_SYS_I(clk), .RST_I(rst), .CC_ROLE_I(role),
    .CC_ATTACH_RAW_I(att_raw), .CC_ACC_RAW_I(acc_raw),
    .VBUS_RAW_I(vb_raw), .MODE_I(mode), .CONTROL_I(ctl),
    .MANUAL_WR_I(mwr), .MANUAL_WE_I(mwe), .TOGGLE_EN_I(tog),
    .SCL_I(pins[0]), .SDA_I(pins[1]), .CC_ATTACHED_O(obs[0]),
    .ACC_ATTACHED_O(obs[1]), .VBUS_VALID_O(obs[2]),
    .VBUS_VALID_IRQ_O(obs[3]), .IN_RECOVERY_O(obs[4]),
    .TOG_SOURCE_O(obs[5]), .SCL_FILT_O(obs[6]), .SDA_FILT_O(obs[7]));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t seen %0d expected %0d", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic step();
    @(posedge clk);
    #1;
  endtask

  task automatic wait_bit(input int b, input logic v, input int lim);
    n = 0;
    while (obs[b] !== v && n < lim)
    begin
      step();
      n++;
    end
    if (obs[b] !== v)
    begin
      fail_count++;
      $display("[ERR] %0t wait ran out on output %0d", $time, b);
      report_and_stop();
    end
  endtask

  task automatic stay(input int b, input logic v, input int cyc);
    repeat (cyc)
    begin
      step();
      check(obs[b], v);
    end
  endtask

  // Dwell is aimed at the midpoint; one cycle of slack either side
  function automatic logic near(input int got, input int ms);
    return (got * 2 >= ms * MSC * 3 - 2) && (got * 2 <= ms * MSC * 3 + 2);
  endfunction

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    repeat (3) step();
    check(obs, 8'h00);
    rst = 1'b0;
    foreach (att_rows[i])
    begin
      role = att_rows[i].sel;
      att = 1'b1;
      wait_bit(0, 1'b1, 100);
      check(n, att_rows[i].a);
      att = 1'b0;
      wait_bit(0, 1'b0, 100);
      check(n, att_rows[i].b);
    end
    acc = 1'b1;
    wait_bit(1, 1'b1, 100);
    check(n, ACC);
    acc = 1'b0;
    wait_bit(1, 1'b0, 100);
    check(n, DET);
    role = 2'h1;
    chat = 1'b1;
    stay(0, 1'b0, 40);
    chat = 1'b0;
    step();
    att = 1'b1;
    repeat (SNK - 1) step();
    att = 1'b0;
    step();
    att = 1'b1;
    wait_bit(0, 1'b1, 100);
    check(n, SNK);
    att = 1'b0;
    wait_bit(0, 1'b0, 100);
    for (int k = 0; k < 2; k++)
    begin
      mwe = (k == 0);
      mwr = 8'h01;
      if (k == 1)
        mode = 6'h10;
      step();
      mwe = 1'b0;
      check(obs[4], 1'b1);
      wait_bit(4, 1'b0, 100);
      check(n, REC);
      check(obs[5], 1'b0);
    end
    mwr = 8'h0E;
    mwe = 1'b1;
    step();
    mwe = 1'b0;
    stay(4, 1'b0, 3);
    for (int b = 0; b < 2; b++)
    begin
      pins[b] = 1'b0;
      stay(6 + b, 1'b1, 10);
      pins[b] = 1'b1;
      stay(6 + b, 1'b1, 5);
      pins[b] = 1'b0;
      wait_bit(6 + b, 1'b0, 50);
      check(n, 11);
      pins[b] = 1'b1;
      wait_bit(6 + b, 1'b1, 50);
    end
    // Serial clock at the fast-mode ceiling: 250 cycles per half period
    repeat (4)
    begin
      pins[0] = ~pins[0];
      wait_bit(6, pins[0], 50);
      check(n, 11);
      repeat (250 - 11) step();
    end
    tog = 1'b1;
    foreach (dw_rows[i])
    begin
      ctl = {2'h0, dw_rows[i].sel, 4'h0};
      wait_bit(5, 1'b1, 3000);
      wait_bit(5, 1'b0, 3000);
      wait_bit(5, 1'b1, 3000);
      check(near(n, dw_rows[i].a), 1'b1);
      wait_bit(5, 1'b0, 3000);
      check(near(n, dw_rows[i].b), 1'b1);
    end
    tog = 1'b0;
    vb = 1'b1;
    wait_bit(2, 1'b1, 80000);
    check(n, 40000);
    step();
    check(obs[3], 1'b1);
    step();
    check(obs[3], 1'b0);
    vb = 1'b0;
    wait_bit(2, 1'b0, 100);
    check(n, VOFF);
    att = 1'b1;
    wait_bit(0, 1'b1, 100);
    rst = 1'b1;
    step();
    check(obs, 8'h00);
    report_and_stop();
  end
endmodule // tcdt_timers_tb
